// ### core/phy_seq_pkg.sv
package phy_seq_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SWING_OFS = 8'h08;
  localparam logic [7:0] COEFF_OFS = 8'h0C;
  localparam logic [7:0] TRAIN_OFS = 8'h10;
  localparam logic [7:0] TAP_OFS = 8'h14;
  // control register fields
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_UNINIT_BIT = 1;
  localparam int CTRL_SWING_BIT = 2;
  localparam int CTRL_SOURCE_BIT = 8;
  localparam int CTRL_MISC_BIT = 9;
  localparam int CTRL_FIRST_BIT = 10;
  localparam int CTRL_DP_BIT = 11;
  localparam int CTRL_FAST_BIT = 12;
  localparam int CTRL_FOUR_BIT = 13;
  localparam logic [5:0] CTRL_CFG_RESET = 6'h00;
  // phy register addresses; group alias at base, lane n at base + stride*(n+1)
  localparam logic [15:0] LANE_STRIDE = 16'h0040;
  localparam logic [15:0] CONTROL_A_ADDR = 16'h1000;
  localparam logic [15:0] COMP_CTRL_ADDR = 16'h2000;
  localparam logic [15:0] COMP_REF_ADDR = 16'h2004;
  localparam logic [15:0] COMP_STAT_ADDR = 16'h200C;
  localparam logic [15:0] COMP_SRC_ADDR = 16'h2020;
  localparam logic [15:0] COMP_PM0_ADDR = 16'h2024;
  localparam logic [15:0] COMP_PM1_ADDR = 16'h2028;
  localparam logic [15:0] CL_CTRL_ADDR = 16'h3014;
  localparam logic [15:0] PCS_CTRL_ADDR = 16'h4004;
  localparam logic [15:0] TX_SWING_ADDR = 16'h5008;
  localparam logic [15:0] TX_COEFF_ADDR = 16'h5010;
  localparam logic [15:0] TX_TRAIN_ADDR = 16'h5014;
  localparam logic [15:0] TX_TAP_ADDR = 16'h501C;
  localparam logic [15:0] TX_CLKDIV_ADDR = 16'h5020;
  // phy field positions and values
  localparam int CLKDIV_SEL_BIT = 31;
  localparam int CLKDIV_DIV_LSB = 29;
  localparam logic [1:0] CLKDIV_BY2 = 2'h1;
  localparam int DCC_MODE_LSB = 20;
  localparam logic [1:0] DCC_CONTINUOUS = 2'h3;
  localparam int KEEPER_BIT = 26;
  localparam int COMP_INIT_BIT = 31;
  localparam int MISC_PD_BIT = 23;
  localparam int IREF_BIT = 24;
  localparam int CL_PD_BIT = 4;
  localparam int SUS_CLK_LSB = 0;
  localparam logic [1:0] SUS_CLK_VAL = 2'h3;
  localparam int LOADGEN_BIT = 31;
  localparam int TRAIN_BIT = 31;
  localparam int SCALE_LSB = 18;
  localparam logic [2:0] SCALE_VAL = 3'h2;
  localparam int VOLT_LSB = 24;
  localparam int PROC_BIT = 26;
  localparam int REF_HI_LSB = 16;
  // sequence lengths
  localparam logic [4:0] INIT_LEN = 5'h0B;
  localparam logic [4:0] UNINIT_LEN = 5'h02;
  localparam logic [4:0] SWING_LEN = 5'h10;

  typedef enum logic [1:0] {SEQ_INIT = 2'h0, SEQ_UNINIT = 2'h1, SEQ_SWING = 2'h2} seq_t;

  typedef struct packed {
    logic is_read;
    logic skip;
    logic group;
    logic [15:0] addr;
    logic [31:0] mask;
    logic [31:0] val;
  } step_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } phy_cmd_t;
endpackage : phy_seq_pkg

// ### core/phy_bringup_seq.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module phy_bringup_seq
  import phy_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // phy register port
  output logic phy_req,
  output phy_cmd_t phy_cmd,
  input wire logic phy_ack,
  input wire logic [31:0] phy_rdata,
  // power state events
  input wire logic deep_idle_exit,
  output logic busy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ISSUE = 3'b010,
    S_WAIT = 3'b100
  } state_t;

  state_t state_r;
  seq_t seq_r;
  logic [4:0] idx_r;
  logic ph_r;
  logic [31:0] rd_r;
  logic [2:0] vp_r;
  logic done_r;
  logic skipped_r;
  logic reinit_r;
  logic [5:0] cfg_r;
  logic [31:0] swing_r;
  logic [31:0] coeff_r;
  logic [31:0] train_r;
  logic [31:0] tap_r;
  step_t st;
  logic [4:0] len;
  logic last;
  logic [31:0] pm0;
  logic [31:0] pm1;
  logic [7:0] ref_hi;
  logic lg;
  logic apb_wr;
  logic start_init;
  logic start_uninit;
  logic start_swing;

  assign apb_wr = psel & penable & pwrite;
  assign start_init = apb_wr && paddr == CTRL_OFS && pwdata[CTRL_INIT_BIT];
  assign start_uninit = apb_wr && paddr == CTRL_OFS && pwdata[CTRL_UNINIT_BIT];
  assign start_swing = apb_wr && paddr == CTRL_OFS && pwdata[CTRL_SWING_BIT];
  assign pready = 1'b1;
  assign busy = state_r != S_IDLE;
  assign phy_req = state_r == S_WAIT;

  // process monitor references by {voltage, process}
  always_comb begin
    pm0 = 32'h62AB67BB;
    pm1 = 32'h51914F96;
    ref_hi = 8'h00;
    case (vp_r)
      3'h2: begin pm0 = 32'h86E172C7; pm1 = 32'h77CA5EAB; end
      3'h3: begin pm0 = 32'h93F87FE1; pm1 = 32'h8AE871C5; end
      3'h4: begin pm0 = 32'h98FA82DD; pm1 = 32'h89E46DC1; end
      3'h5: begin pm0 = 32'h9A00AB25; pm1 = 32'h8AE38FF1; ref_hi = 8'h44; end
      default: begin pm0 = 32'h62AB67BB; pm1 = 32'h51914F96; end
    endcase
  end

  // step table
  always_comb begin
    st = '0;
    st.mask = 32'hFFFFFFFF;
    lg = 1'b0;
    case (seq_r)
      SEQ_INIT: len = INIT_LEN;
      SEQ_UNINIT: len = UNINIT_LEN;
      default: len = SWING_LEN;
    endcase
    case (seq_r)
      SEQ_INIT: begin
        case (idx_r)
          5'h00: begin
            st.group = 1'b1;
            st.addr = TX_CLKDIV_ADDR;
            st.mask = 32'h0;
            st.mask[CLKDIV_SEL_BIT] = 1'b1;
            st.mask[CLKDIV_DIV_LSB +: 2] = 2'h3;
            st.val = 32'h0;
            st.val[CLKDIV_SEL_BIT] = 1'b1;
            st.val[CLKDIV_DIV_LSB +: 2] = CLKDIV_BY2;
          end
          5'h01: begin
            st.group = 1'b1;
            st.addr = PCS_CTRL_ADDR;
            st.mask = 32'h0;
            st.mask[DCC_MODE_LSB +: 2] = 2'h3;
            st.val = 32'h0;
            st.val[DCC_MODE_LSB +: 2] = DCC_CONTINUOUS;
          end
          5'h02: begin st.is_read = 1'b1; st.addr = COMP_CTRL_ADDR; end
          5'h03: begin
            st.skip = ~cfg_r[CTRL_MISC_BIT - CTRL_SOURCE_BIT];
            st.addr = CONTROL_A_ADDR;
            st.mask = 32'h1 << MISC_PD_BIT;
            st.val = 32'h0;
          end
          5'h04: begin st.is_read = 1'b1; st.addr = COMP_STAT_ADDR; end
          5'h05: begin
            st.addr = COMP_REF_ADDR;
            st.mask = 32'h00FF00FF;
            st.val = {8'h00, ref_hi, 16'h0000};
          end
          5'h06: begin st.addr = COMP_PM0_ADDR; st.val = pm0; end
          5'h07: begin st.addr = COMP_PM1_ADDR; st.val = pm1; end
          5'h08: begin
            st.skip = ~cfg_r[0];
            st.addr = COMP_SRC_ADDR;
            st.mask = 32'h1 << IREF_BIT;
            st.val = 32'h1 << IREF_BIT;
          end
          5'h09: begin
            st.addr = COMP_CTRL_ADDR;
            st.mask = 32'h1 << COMP_INIT_BIT;
            st.val = 32'h1 << COMP_INIT_BIT;
          end
          default: begin
            st.addr = CL_CTRL_ADDR;
            st.mask = 32'h1 << CL_PD_BIT;
            st.val = 32'h1 << CL_PD_BIT;
          end
        endcase
      end
      SEQ_UNINIT: begin
        if (idx_r == 5'h00) begin
          st.skip = ~cfg_r[CTRL_MISC_BIT - CTRL_SOURCE_BIT];
          st.addr = CONTROL_A_ADDR;
          st.mask = 32'h1 << MISC_PD_BIT;
          st.val = 32'h1 << MISC_PD_BIT;
        end else begin
          st.addr = COMP_CTRL_ADDR;
          st.mask = 32'h1 << COMP_INIT_BIT;
          st.val = 32'h0;
        end
      end
      default: begin
        case (idx_r)
          5'h00: begin
            st.group = 1'b1;
            st.addr = PCS_CTRL_ADDR;
            st.mask = 32'h1 << KEEPER_BIT;
            st.val = {31'h0, cfg_r[CTRL_DP_BIT - CTRL_SOURCE_BIT]} << KEEPER_BIT;
          end
          5'h01, 5'h02, 5'h03, 5'h04: begin
            case (idx_r)
              5'h02, 5'h03: lg = ~cfg_r[CTRL_FAST_BIT - CTRL_SOURCE_BIT];
              5'h04: lg = ~cfg_r[CTRL_FAST_BIT - CTRL_SOURCE_BIT] &
                cfg_r[CTRL_FOUR_BIT - CTRL_SOURCE_BIT];
              default: lg = 1'b0;
            endcase
            st.addr = TX_COEFF_ADDR + LANE_STRIDE * {11'h0, idx_r};
            st.mask = 32'h1 << LOADGEN_BIT;
            st.val = {31'h0, lg} << LOADGEN_BIT;
          end
          5'h05: begin
            st.addr = CL_CTRL_ADDR;
            st.mask = 32'h3 << SUS_CLK_LSB;
            st.val = {30'h0, SUS_CLK_VAL} << SUS_CLK_LSB;
          end
          5'h06: begin
            st.group = 1'b1;
            st.addr = TX_TRAIN_ADDR;
            st.mask = 32'h1 << TRAIN_BIT;
            st.val = 32'h0;
          end
          5'h07: begin
            st.group = 1'b1;
            st.addr = TX_TRAIN_ADDR;
            st.mask = 32'h7 << SCALE_LSB;
            st.val = {29'h0, SCALE_VAL} << SCALE_LSB;
          end
          5'h08: begin st.group = 1'b1; st.addr = TX_SWING_ADDR; st.val = swing_r; end
          5'h09, 5'h0A, 5'h0B, 5'h0C: begin
            st.addr = TX_COEFF_ADDR + LANE_STRIDE * {11'h0, idx_r - 5'h08};
            st.mask = ~(32'h1 << LOADGEN_BIT);
            st.val = coeff_r;
          end
          5'h0D: begin
            st.group = 1'b1;
            st.addr = TX_TRAIN_ADDR;
            st.mask = ~((32'h1 << TRAIN_BIT) | (32'h7 << SCALE_LSB));
            st.val = train_r;
          end
          5'h0E: begin st.group = 1'b1; st.addr = TX_TAP_ADDR; st.val = tap_r; end
          default: begin
            st.group = 1'b1;
            st.addr = TX_TRAIN_ADDR;
            st.mask = 32'h1 << TRAIN_BIT;
            st.val = 32'h1 << TRAIN_BIT;
          end
        endcase
      end
    endcase
    last = idx_r == len - 5'h01;
  end

  // sequencer: each step not skipped reads (lane 0 for a group), then writes unless it is a read step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      seq_r <= SEQ_INIT;
      idx_r <= 5'h00;
      ph_r <= 1'b0;
      rd_r <= 32'h0;
      vp_r <= 3'h0;
      phy_cmd <= '0;
      done_r <= 1'b0;
      skipped_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_init | start_uninit | start_swing) begin
            seq_r <= start_init ? SEQ_INIT : (start_uninit ? SEQ_UNINIT : SEQ_SWING);
            idx_r <= 5'h00;
            ph_r <= 1'b0;
            done_r <= 1'b0;
            skipped_r <= 1'b0;
            state_r <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (st.skip) begin
            if (last) begin
              state_r <= S_IDLE;
              done_r <= 1'b1;
            end else begin
              idx_r <= idx_r + 5'h01;
            end
          end else begin
            phy_cmd.we <= ph_r;
            phy_cmd.addr <= (st.group && !ph_r) ? st.addr + LANE_STRIDE : st.addr;
            phy_cmd.wdata <= (rd_r & ~st.mask) | (st.val & st.mask);
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (phy_ack) begin
            ph_r <= 1'b0;
            if (!ph_r) begin
              rd_r <= phy_rdata;
            end
            if (!ph_r && !st.is_read) begin
              ph_r <= 1'b1;
              state_r <= S_ISSUE;
            end else if (st.is_read && seq_r == SEQ_INIT && idx_r == 5'h02 &&
                phy_rdata[COMP_INIT_BIT]) begin
              state_r <= S_IDLE;
              done_r <= 1'b1;
              skipped_r <= 1'b1;
            end else if (last) begin
              state_r <= S_IDLE;
              done_r <= 1'b1;
            end else begin
              if (st.is_read && idx_r == 5'h04) begin
                vp_r <= {phy_rdata[VOLT_LSB +: 2], phy_rdata[PROC_BIT]};
              end
              idx_r <= idx_r + 5'h01;
              state_r <= S_ISSUE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // non-first ports lose their state in deep idle; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reinit_r <= 1'b0;
    end else if (deep_idle_exit && !cfg_r[CTRL_FIRST_BIT - CTRL_SOURCE_BIT]) begin
      reinit_r <= 1'b1;
    end else if (state_r == S_WAIT && phy_ack && ph_r && seq_r == SEQ_INIT && last) begin
      reinit_r <= 1'b0;
    end
  end

  // apb register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CTRL_CFG_RESET;
      swing_r <= 32'h0;
      coeff_r <= 32'h0;
      train_r <= 32'h0;
      tap_r <= 32'h0;
    end else if (apb_wr) begin
      case (paddr)
        CTRL_OFS: cfg_r <= pwdata[CTRL_FOUR_BIT:CTRL_SOURCE_BIT];
        SWING_OFS: swing_r <= pwdata;
        COEFF_OFS: coeff_r <= pwdata;
        TRAIN_OFS: train_r <= pwdata;
        TAP_OFS: tap_r <= pwdata;
        default: ;
      endcase
    end
  end

  // apb read mux and error answer
  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      CTRL_OFS: prdata = {18'h0, cfg_r, 8'h00};
      STATUS_OFS: prdata = {16'h0, 3'h0, idx_r, 4'h0, reinit_r, skipped_r, done_r, busy};
      SWING_OFS: prdata = swing_r;
      COEFF_OFS: prdata = coeff_r;
      TRAIN_OFS: prdata = train_r;
      TAP_OFS: prdata = tap_r;
      default: pslverr = psel & penable;
    endcase
  end
endmodule : phy_bringup_seq

// ### dv/phy_regs_model.sv
`timescale 1ns/1ps
module phy_regs_model
  import phy_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access port
  input wire logic phy_req,
  input wire phy_cmd_t phy_cmd,
  output logic phy_ack,
  output logic [31:0] phy_rdata,
  // answer delay in cycles
  input wire logic [3:0] dly
);
  // contents survive every idle exit
  logic [31:0] mem [logic [15:0]];
  phy_cmd_t wlog [$];
  int applied = 0;
  logic [3:0] cnt_r;
  logic [31:0] old_v;
  wire logic alias_w = phy_cmd.addr[15:12] >= 4'h4 && (phy_cmd.addr & 16'h0FC0) == 16'h0;
  function automatic logic [31:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction : rd
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phy_ack <= 1'b0;
      cnt_r <= 4'h0;
      phy_rdata <= 32'h0;
    end else begin
      phy_ack <= 1'b0;
      phy_rdata <= ~phy_rdata;
      if (phy_req && !phy_ack && cnt_r != dly) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (phy_req && !phy_ack) begin
        cnt_r <= 4'h0;
        phy_ack <= 1'b1;
        old_v = rd(phy_cmd.addr + LANE_STRIDE);
        if (phy_cmd.we) begin
          wlog.push_back(phy_cmd);
          // a new training enable applies the swing
          if (phy_cmd.addr == TX_TRAIN_ADDR && phy_cmd.wdata[TRAIN_BIT] && !old_v[TRAIN_BIT]) begin
            applied++;
          end
          mem[phy_cmd.addr] = phy_cmd.wdata;
          if (alias_w) begin
            for (int k = 1; k < 5; k++) begin
              mem[phy_cmd.addr + LANE_STRIDE * 16'(k)] = phy_cmd.wdata;
            end
          end
        end else begin
          // group reads give no usable data
          phy_rdata <= alias_w ? ~old_v : rd(phy_cmd.addr);
        end
      end
    end
  end
endmodule : phy_regs_model

// ### dv/phy_bringup_seq_asserts.sv
`timescale 1ns/1ps
module phy_bringup_seq_asserts
  import phy_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // phy port
  input wire logic phy_req,
  input wire phy_cmd_t phy_cmd,
  input wire logic phy_ack,
  input wire logic [31:0] phy_rdata,
  // power events
  input wire logic deep_idle_exit,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_w = phy_req && phy_cmd.we;
  wire logic acc_w = psel && penable;
  property p_hold; phy_req && !phy_ack |=> phy_req && $stable(phy_cmd); endproperty
  a_hold: assert property (p_hold) else $error("phy command moved before ack");
  property p_drop; phy_req && phy_ack |=> !phy_req; endproperty
  a_drop: assert property (p_drop) else $error("phy request held after ack");
  property p_busy; phy_req |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("phy access outside a sequence");
  property p_start;
    acc_w && pwrite && paddr == CTRL_OFS && pwdata[CTRL_INIT_BIT] && !busy |-> ##[1:2] busy;
  endproperty
  a_start: assert property (p_start) else $error("start did not raise busy");
  property p_unmap; acc_w && paddr > TAP_OFS |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_lane; phy_req |-> phy_cmd.addr != TX_COEFF_ADDR; endproperty
  a_lane: assert property (p_lane) else $error("coefficient word via group address");
  property p_rdal;
    phy_req && !phy_cmd.we && phy_cmd.addr[15:12] >= 4'h4 |-> (phy_cmd.addr & 16'h0FC0) != 16'h0;
  endproperty
  a_rdal: assert property (p_rdal) else $error("read from group address");
  property p_lg0;
    wr_w && phy_cmd.addr == TX_COEFF_ADDR + LANE_STRIDE |-> !phy_cmd.wdata[LOADGEN_BIT];
  endproperty
  a_lg0: assert property (p_lg0) else $error("lane 0 loadgen set");
  property p_div; wr_w && phy_cmd.addr == TX_CLKDIV_ADDR |-> phy_cmd.wdata[30:29] == CLKDIV_BY2;
  endproperty
  a_div: assert property (p_div) else $error("divider select wrong");
  property p_dcc; wr_w && phy_cmd.addr == PCS_CTRL_ADDR |-> phy_cmd.wdata[21:20] == DCC_CONTINUOUS;
  endproperty
  a_dcc: assert property (p_dcc) else $error("duty correction mode wrong");
  c_wr: cover property (phy_ack && phy_cmd.we);
  c_err: cover property (pslverr);
  c_done: cover property ($fell(busy));
endmodule : phy_bringup_seq_asserts

bind phy_bringup_seq phy_bringup_seq_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phy_req(phy_req), .phy_cmd(phy_cmd),
  .phy_ack(phy_ack), .phy_rdata(phy_rdata), .deep_idle_exit(deep_idle_exit), .busy(busy));

// ### dv/combo_phy_bringup_swing_seq_tb_top.sv
`timescale 1ns/1ps
module combo_phy_bringup_swing_seq_tb_top
  import phy_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle_x = 1'b0, sv_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv, phy_rdata;
  logic pready, pslverr, phy_req, phy_ack, busy;
  phy_cmd_t phy_cmd;
  logic [3:0] dly = 4'h0;
  logic [2:0] cf;
  int err_total = 0, check_count = 0, n0, a0, i_clr, i_sw;
  always #5 clk = ~clk;
  phy_bringup_seq u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_req(phy_req), .phy_cmd(phy_cmd), .phy_ack(phy_ack),
    .phy_rdata(phy_rdata), .deep_idle_exit(idle_x), .busy(busy));
  phy_regs_model u_phy (.clk(clk), .rst(rst), .phy_req(phy_req), .phy_cmd(phy_cmd),
    .phy_ack(phy_ack), .phy_rdata(phy_rdata), .dly(dly));
  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      report_and_stop();
    end
  endtask : guard
  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdv = prdata;
    sv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    guard(n, 16);
    @(posedge clk);
  endtask : apb
  task automatic run(input logic [31:0] c);
    int n;
    apb(1'b1, CTRL_OFS, c);
    for (n = 0; n < 3000; n++) begin
      if (busy === 1'b0) break;
      @(posedge clk);
    end
    guard(n, 3000);
  endtask : run
  task automatic pulse();
    idle_x <= 1'b1;
    @(posedge clk);
    idle_x <= 1'b0;
    @(posedge clk);
  endtask : pulse
  function automatic logic [15:0] ln(input logic [15:0] b, input int k);
    return b + LANE_STRIDE * 16'(k + 1);
  endfunction : ln
  // cfg bits are four lanes, above 6 GHz, dp type
  function automatic logic lgx(input logic [2:0] c, input int k);
    return k != 0 && !c[1] && (k < 3 || c[2]);
  endfunction : lgx
  function automatic logic [31:0] wl(input int i, input logic dat);
    return dat ? u_phy.wlog[i].wdata : {16'h0, u_phy.wlog[i].addr};
  endfunction : wl
  initial begin
    u_phy.mem[COMP_STAT_ADDR] = 32'h0600_0000;
    u_phy.mem[CONTROL_A_ADDR] = 32'h0080_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({sv_err, rdv[30:0]}, 32'h8000_0000);
    $display("test reset done");
    // source is brought up first, before any sink or io power
    run(32'h0000_0701);
    chk(u_phy.rd(COMP_PM0_ADDR), 32'h9A00AB25);
    chk(u_phy.rd(COMP_PM1_ADDR), 32'h8AE38FF1);
    chk(u_phy.rd(COMP_REF_ADDR) & 32'h00FF_00FF, 32'h0044_0000);
    chk(u_phy.rd(COMP_SRC_ADDR) & 32'h0100_0000, 32'h0100_0000);
    chk(u_phy.rd(CONTROL_A_ADDR) & 32'h0080_0000, 32'h0);
    for (int k = 0; k < 4; k++) begin
      chk(u_phy.rd(ln(TX_CLKDIV_ADDR, k)) & 32'h6000_0000, 32'h2000_0000);
      chk(u_phy.rd(ln(PCS_CTRL_ADDR, k)) & 32'h0030_0000, 32'h0030_0000);
    end
    n0 = u_phy.wlog.size();
    chk(wl(n0 - 2, 0), {16'h0, COMP_CTRL_ADDR});
    chk(wl(n0 - 2, 1) & 32'h8000_0000, 32'h8000_0000);
    chk(wl(n0 - 1, 0), {16'h0, CL_CTRL_ADDR});
    chk(wl(n0 - 1, 1) & 32'h10, 32'h10);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv & 32'h6, 32'h2);
    $display("test init done");
    run(32'h0000_0701);
    chk(u_phy.wlog.size() - n0, 32'h2);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv & 32'h4, 32'h4);
    $display("test skip done");
    // only for the deepest power state, with no other phy in use
    run(32'h0000_0702);
    n0 = u_phy.wlog.size();
    chk(wl(n0 - 2, 0), {16'h0, CONTROL_A_ADDR});
    chk(wl(n0 - 2, 1) & 32'h0080_0000, 32'h0080_0000);
    chk(wl(n0 - 1, 0), {16'h0, COMP_CTRL_ADDR});
    chk(wl(n0 - 1, 1) & 32'h8000_0000, 32'h0);
    $display("test uninit done");
    u_phy.mem[COMP_STAT_ADDR] = 32'h0;
    u_phy.mem[COMP_SRC_ADDR] = 32'h0;
    dly <= 4'h4;
    run(32'h0000_0201);
    chk(u_phy.rd(COMP_PM0_ADDR), 32'h62AB67BB);
    chk(u_phy.rd(COMP_PM1_ADDR), 32'h51914F96);
    chk(u_phy.rd(COMP_REF_ADDR) & 32'h00FF_00FF, 32'h0);
    chk(u_phy.rd(COMP_SRC_ADDR) & 32'h0100_0000, 32'h0);
    chk(u_phy.rd(COMP_CTRL_ADDR) & 32'h8000_0000, 32'h8000_0000);
    $display("test reinit done");
    apb(1'b1, CTRL_OFS, 32'h0000_0400);
    pulse();
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv & 32'h8, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
    pulse();
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rdv & 32'h8, 32'h8);
    $display("test idle done");
    apb(1'b1, SWING_OFS, 32'h0000_A5A5);
    apb(1'b1, COEFF_OFS, 32'h8000_1234);
    apb(1'b1, TRAIN_OFS, 32'h0000_00C3);
    apb(1'b1, TAP_OFS, 32'h0000_0055);
    for (int i = 0; i < 3; i++) begin
      cf = (i == 0) ? 3'b101 : (i == 1) ? 3'b000 : 3'b111;
      dly <= 4'(i * 3);
      n0 = u_phy.wlog.size();
      a0 = u_phy.applied;
      run({18'h0, cf, 11'h004});
      i_clr = -1;
      i_sw = -1;
      for (int j = n0; j < u_phy.wlog.size(); j++) begin
        if (wl(j, 0) == TX_TRAIN_ADDR && !u_phy.wlog[j].wdata[TRAIN_BIT] && i_clr < 0) i_clr = j;
        if (wl(j, 0) == TX_SWING_ADDR && i_sw < 0) i_sw = j;
      end
      chk(32'(i_clr >= 0 && i_clr < i_sw), 32'h1);
      chk(u_phy.applied - a0, 32'h1);
      chk(u_phy.rd(CL_CTRL_ADDR) & 32'h3, 32'h3);
      for (int k = 0; k < 4; k++) begin
        chk(u_phy.rd(ln(TX_COEFF_ADDR, k)), {lgx(cf, k), 31'h1234});
        chk(u_phy.rd(ln(PCS_CTRL_ADDR, k)) & 32'h0400_0000, {5'h0, cf[0], 26'h0});
        chk(u_phy.rd(ln(TX_TRAIN_ADDR, k)) & 32'h801C_00FF, 32'h8008_00C3);
        chk(u_phy.rd(ln(TX_SWING_ADDR, k)), 32'h0000_A5A5);
      end
      $display("test swing %0d done", i);
    end
    report_and_stop();
  end
endmodule : combo_phy_bringup_swing_seq_tb_top
